// *** src/adc_result_regs.sv ***
// result, compare and analog pin control registers of the converter
`timescale 1ns/10ps
`include "adc_regs_defines.svh"
module adc_result_regs (
  input wire logic clk,
  input wire logic nrst,
  input adc_regs_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  input adc_regs_pkg::conv_t conv,
  input adc_regs_pkg::cfg_t cfg,
  input wire logic [3:0] chan_fifo_count,
  output logic start_set,
  output logic result_taken,
  output logic result_lost,
  output adc_regs_pkg::pin_ctl_t pins
);
  import adc_regs_pkg::*;
  // all block state except the result queue, which u_fifo holds
  typedef struct packed {
    logic [11:0] result;
    logic [11:0] compare;
    logic [15:0] pin_dis;
    logic blocked;
    logic [1:0] mode;
    logic [7:0] rdata;
    logic taken;
    logic lost;
  } st_t;
  st_t q, d;
  logic fifo_on, cmp_ok, in_ready, out_valid, fifo_pop, fifo_push;
  logic [11:0] fifo_data;
  logic [3:0] fifo_cnt;
  logic [3:0] depth;
  logic rd_hi, rd_lo, interlock;

  // result queue; when it is full a new result is dropped and flagged lost
  adc_result_fifo #(.W(12), .D(`FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(!fifo_on || (cfg.mode != q.mode)),
    .in_valid(fifo_push),
    .in_ready(in_ready),
    .in_data(conv.value),
    .out_valid(out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .count(fifo_cnt)
  );

  // decode, compare, transfer and interlock
  always_comb begin
    fifo_on = (cfg.fifo_depth_select != `DEPTH_OFF);
    depth = {1'b0, cfg.fifo_depth_select} + 4'h1;
    start_set = fifo_on && (chan_fifo_count >= depth);
    rd_hi = bus.rd && (bus.addr == `OFS_RESULT_HIGH);
    rd_lo = bus.rd && (bus.addr == `OFS_RESULT_LOW);
    interlock = (cfg.mode != `MODE_8BIT);
    // equality on both halves; gates it
    cmp_ok = !cfg.compare_enable || (conv.value == q.compare);
    fifo_push = conv.done && fifo_on && cmp_ok && !q.blocked;
    fifo_pop = rd_lo && fifo_on && out_valid;
    d = q;
    d.taken = 1'b0;
    d.lost = 1'b0;
    d.mode = cfg.mode;
    // reading high arms the lock outside 8-bit mode, reading low frees it
    if (rd_hi && interlock) begin
      d.blocked = 1'b1;
    end
    if (rd_lo || !interlock) begin
      d.blocked = 1'b0;
    end
    if (fifo_on) begin
      d.result = out_valid ? fifo_data : q.result;
      d.taken = fifo_push && in_ready;
      d.lost = conv.done && cmp_ok && (q.blocked || !in_ready);
    end else if (conv.done && cmp_ok) begin
      if (q.blocked) begin
        d.lost = 1'b1;
      end else begin
        d.result = conv.value;
        d.taken = 1'b1;
      end
    end
    if (cfg.mode != q.mode) begin
      d.result = `RST_RESULT;
      d.blocked = 1'b0;
    end
    // register writes; results are read only
    if (bus.wr) begin
      case (bus.addr)
        `OFS_CMP_HIGH: d.compare[11:8] = bus.wdata[3:0];
        `OFS_CMP_LOW: d.compare[7:0] = bus.wdata;
        `OFS_PIN_DIS_LOW: d.pin_dis[7:0] = bus.wdata;
        `OFS_PIN_DIS_HIGH: d.pin_dis[15:8] = bus.wdata;
        default: ;
      endcase
    end
    // read data, presented one cycle after the strobe
    d.rdata = `RST_BYTE;
    if (bus.rd) begin
      case (bus.addr)
        `OFS_RESULT_HIGH: d.rdata = {4'h0, q.result[11:8]};
        `OFS_RESULT_LOW: d.rdata = q.result[7:0];
        `OFS_CMP_HIGH: d.rdata = {4'h0, q.compare[11:8]};
        `OFS_CMP_LOW: d.rdata = q.compare[7:0];
        `OFS_PIN_DIS_LOW: d.rdata = q.pin_dis[7:0];
        `OFS_PIN_DIS_HIGH: d.rdata = q.pin_dis[15:8];
        default: d.rdata = `RST_BYTE;
      endcase
    end
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs from flops
  always_comb begin
    rdata = q.rdata;
    result_taken = q.taken;
    result_lost = q.lost;
    pins.pin_disable = q.pin_dis;
    pins.pullup_off = q.pin_dis;
    pins.in_buf_off = q.pin_dis;
  end
endmodule

// *** src/adc_regs_defines.svh ***
// register offsets, field positions, reset values and encodings
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH
`define ADDR_W 14
`define OFS_RESULT_HIGH 14'h0004
`define OFS_RESULT_LOW 14'h0005
`define OFS_CMP_HIGH 14'h0006
`define OFS_CMP_LOW 14'h0007
`define OFS_PIN_DIS_LOW 14'h309C
`define OFS_PIN_DIS_HIGH 14'h309D
`define RST_BYTE 8'h00
`define RST_RESULT 12'h000
`define HIGH_NIBBLE_MASK 8'h0F
`define FIFO_DEPTH 8
`define MODE_8BIT 2'h0
`define DEPTH_OFF 3'h0
`endif

// *** src/adc_regs_pkg.sv ***
// types shared by the result, compare and pin control logic
package adc_regs_pkg;
  // software register port
  typedef struct packed {
    logic [13:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  // finished conversion from the converter core
  typedef struct packed {
    logic done;
    logic [11:0] value;
  } conv_t;
  // converter configuration from the control registers
  typedef struct packed {
    logic compare_enable;
    logic [1:0] mode;
    logic [2:0] fifo_depth_select;
    logic chan_push;
  } cfg_t;
  // pin steering outputs
  typedef struct packed {
    logic [15:0] pin_disable;
    logic [15:0] pullup_off;
    logic [15:0] in_buf_off;
  } pin_ctl_t;
endpackage

// *** src/adc_result_fifo.sv ***
// result fifo with parameterised width and depth
`timescale 1ns/10ps
module adc_result_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  // pointer and count state in one struct; storage words kept apart
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fst_t;
  fst_t q, d;
  logic [W-1:0] mem [D];  // storage words
  logic push, pop;
  // handshake is combinational, storage count honest
  always_comb begin
    in_ready = (q.cnt != (AW+1)'(D));
    out_valid = (q.cnt != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    out_data = mem[q.rp];
    count = q.cnt;
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      d = '0;
    end
  end
  // pointer register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  // storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
endmodule

// *** tb/adc_result_regs_chk.sv ***
// port checker for the result, compare and pin registers
`timescale 1ns/10ps
`include "adc_regs_defines.svh"
module adc_result_regs_chk (
  input wire logic clk,
  input wire logic nrst,
  input adc_regs_pkg::bus_req_t bus,
  input wire logic [7:0] rdata,
  input adc_regs_pkg::conv_t conv,
  input adc_regs_pkg::cfg_t cfg,
  input wire logic [3:0] chan_fifo_count,
  input wire logic start_set,
  input wire logic result_taken,
  input wire logic result_lost,
  input adc_regs_pkg::pin_ctl_t pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // reserved top nibbles must never leak through a read
  chk_top_zero: assert property (bus.rd && bus.addr inside
    {`OFS_RESULT_HIGH, `OFS_CMP_HIGH} |=> rdata[7:4] == 4'h0) else $error("top");
  chk_start_level: assert property (start_set ==
    (cfg.fifo_depth_select != 3'h0 && chan_fifo_count >
    {1'b0, cfg.fifo_depth_select})) else $error("start level");
  chk_pin_low: assert property (bus.wr && bus.addr == `OFS_PIN_DIS_LOW
    |=> pins.pin_disable[7:0] == $past(bus.wdata)) else $error("pin low");
  chk_pin_high: assert property (bus.wr && bus.addr == `OFS_PIN_DIS_HIGH
    |=> pins.pin_disable[15:8] == $past(bus.wdata)) else $error("pin high");
  chk_pin_steer: assert property (pins.pullup_off == pins.pin_disable &&
    pins.in_buf_off == pins.pin_disable) else $error("pin steer");
  // stable config only: a mode change clears the result at that edge
  chk_no_lock8: assert property (conv.done && cfg.mode == `MODE_8BIT &&
    $stable(cfg) && !cfg.compare_enable && cfg.fifo_depth_select == 3'h0
    |=> result_taken) else $error("8-bit result dropped");
  chk_taken_cause: assert property (result_taken |->
    $past(conv.done)) else $error("taken without conversion");
  chk_lost_cause: assert property (result_lost |->
    $past(conv.done)) else $error("lost without conversion");
endmodule
bind adc_result_regs adc_result_regs_chk chk_u (.clk, .nrst, .bus, .rdata,
  .conv, .cfg, .chan_fifo_count, .start_set, .result_taken, .result_lost, .pins);

// *** tb/adc_result_regs_tb.sv ***
// self-checking bench for the result, compare and pin registers
`timescale 1ns/10ps
`include "adc_regs_defines.svh"
module adc_result_regs_tb;
  import adc_regs_pkg::*;
  logic clk = 0, nrst = 0;
  bus_req_t bus = '0;
  conv_t conv = '0;
  cfg_t cfg = '0;
  logic [3:0] chan_fifo_count = 4'h0;
  logic [7:0] rdata, a, b;
  logic start_set, result_taken, result_lost;
  pin_ctl_t pins;
  int num_errors = 0, checks_done = 0;
  logic [11:0] v, w, q [4];
  adc_result_regs dut_u (.clk, .nrst, .bus, .rdata, .conv, .cfg,
    .chan_fifo_count, .start_set, .result_taken, .result_lost, .pins);
  initial forever #12.5 clk = ~clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [13:0] ad, input logic [7:0] d);
    @(posedge clk) bus <= {ad, d, 2'b10};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input logic [13:0] ad, input logic [7:0] e);
    @(posedge clk) bus <= {ad, 8'h00, 2'b01};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task cv(input logic [11:0] x);
    @(posedge clk) conv <= {1'b1, x};
    @(posedge clk) conv.done <= 1'b0;
  endtask
  // high read arms the interlock outside 8-bit mode, low read frees it
  task pair(input logic [11:0] x);
    rd(`OFS_RESULT_HIGH, {4'h0, x[11:8]});
    rd(`OFS_RESULT_LOW, x[7:0]);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far beyond the roughly 115 cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  initial begin
    v = $urandom(32'h9d09);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(`OFS_PIN_DIS_HIGH, `RST_BYTE);
    repeat (3) begin
      a = $urandom;
      b = $urandom;
      wr(`OFS_PIN_DIS_LOW, a);
      wr(`OFS_PIN_DIS_HIGH, b);
      rd(`OFS_PIN_DIS_LOW, a);
      chk(pins.pin_disable, {b, a});
      chk(pins.pullup_off, {b, a});
      chk(pins.in_buf_off, {b, a});
    end
    wr(`OFS_CMP_HIGH, 8'hFF);
    rd(`OFS_CMP_HIGH, `HIGH_NIBBLE_MASK);
    rd(14'h0123, `RST_BYTE);
    @(posedge clk) cfg.mode <= 2'h1;
    v = $urandom;
    w = $urandom;
    cv(v);
    #1 chk({15'h0000, result_taken}, 16'h0001);
    rd(`OFS_RESULT_HIGH, {4'h0, v[11:8]});
    cv(w);
    #1 chk({15'h0000, result_lost}, 16'h0001);
    rd(`OFS_RESULT_LOW, v[7:0]);
    cv(w);
    pair(w);
    wr(`OFS_CMP_HIGH, 8'h05);
    wr(`OFS_CMP_LOW, 8'hA5);
    @(posedge clk) cfg.compare_enable <= 1'b1;
    cv(12'h5A4);
    pair(w);
    cv(12'h4A5);
    pair(w);
    cv(12'h5A5);
    pair(12'h5A5);
    @(posedge clk) cfg <= '0;
    rd(`OFS_RESULT_LOW, `RST_BYTE);
    rd(`OFS_RESULT_HIGH, `RST_BYTE);
    cv(v);
    rd(`OFS_RESULT_LOW, v[7:0]);
    @(posedge clk) cfg <= {1'b0, 2'h1, 3'h3, 1'b0};
    chan_fifo_count <= 4'h3;
    #1 chk({15'h0000, start_set}, 16'h0000);
    @(posedge clk) chan_fifo_count <= 4'h4;
    #1 chk({15'h0000, start_set}, 16'h0001);
    foreach (q[i]) begin
      q[i] = $urandom;
      cv(q[i]);
    end
    foreach (q[i]) pair(q[i]);
    stop_test;
  end
endmodule
